/* File: hw/cpwm_params.svh */
// Constants of the complementary PWM timer: offsets, fields, reset values, timings
// Operation
// RULE_01: Change count source only while counter stopped
// RULE_02: Wait two base clocks before stopping 40 MHz
// RULE_03: Wait two fast clocks after fast-to-40MHz switch
// RULE_04: Wait fast plus 40 MHz cycle otherwise
// RULE_05: Code 111b selects fast oscillator, faster than CPU
// RULE_06: Code 110b selects 40 MHz oscillator source
// RULE_07: Capture pulse lasts three operating clocks minimum
// RULE_08: Capture lands two or three clocks after edge
// RULE_09: Reset-sync PWM entry: stop, 00b, 01b, reprogram
// RULE_10: Motor use needs equal initial levels
// RULE_11: Complementary entry: stop both, 00b, 10b/11b
// RULE_12: Leave complementary: stop both, write 00b
// RULE_13: No direct period or duty writes running
// RULE_14: Write duty buffers while configured as general
// RULE_15: Channel 0 turns m-1,m,m+1,m; flag at m+1
// RULE_16: Mode 11b transfers buffers at period match
// RULE_17: No flag or transfer on way down
// RULE_18: Channel 1 turns 1,0,FFFFh; underflow flag set
// RULE_19: Mode 10b transfers at underflow, overflow untouched
// RULE_20: Buffer at or above period transfers at underflow
// RULE_21: Buffer zero transfers at period match
// RULE_22: Counters are 16 bits and wrap
`ifndef CPWM_PARAMS_SVH
`define CPWM_PARAMS_SVH
`define CPWM_OFS_START 8'h00
`define CPWM_OFS_FUNC 8'h04
`define CPWM_OFS_CTRL0 8'h08
`define CPWM_OFS_CTRL1 8'h0c
`define CPWM_OFS_STATUS 8'h10
`define CPWM_OFS_CNT0 8'h14
`define CPWM_OFS_CNT1 8'h18
`define CPWM_OFS_PERIOD 8'h1c
`define CPWM_OFS_GR_B0 8'h20
`define CPWM_OFS_GR_A1 8'h24
`define CPWM_OFS_GR_B1 8'h28
`define CPWM_OFS_BUF_D0 8'h2c
`define CPWM_OFS_BUF_C1 8'h30
`define CPWM_OFS_BUF_D1 8'h34
`define CPWM_OFS_CAP0 8'h38
`define CPWM_OFS_CAP1 8'h3c
`define CPWM_SRC_40M 3'h6
`define CPWM_SRC_FAST 3'h7
`define CPWM_ST_PMF 0
`define CPWM_ST_UDF 1
`define CPWM_ST_OVF 2
`define CPWM_CAP_DELAY 2'h2
`define CPWM_PERIOD_RST 16'hffff
`endif

/* File: hw/cpwm_pkg.sv */
// Types of the complementary PWM timer
package cpwm_pkg;
  typedef enum logic [1:0] {
    CPWM_MODE_INDEP = 2'b00,
    CPWM_MODE_RSYNC = 2'b01,
    CPWM_MODE_CUDF = 2'b10,
    CPWM_MODE_CMAT = 2'b11
  } cpwm_mode_t;
  typedef enum logic [1:0] {
    CPWM_XF_NORMAL = 2'b00,
    CPWM_XF_HIGH = 2'b01,
    CPWM_XF_ZERO = 2'b10
  } cpwm_xfer_t;
endpackage

/* File: hw/cpwm_timer.sv */
// Complementary PWM timer pair with AHB-Lite register slave
`timescale 1ns/1ps
`include "cpwm_params.svh"
module cpwm_timer import cpwm_pkg::*; #(
  parameter int CW = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic base_peripheral_clock,
  input wire logic internal_40mhz_clock,
  input wire logic fast_internal_osc_clock,
  input wire logic [1:0] capture_in,
  output logic [2:0] pwm_positive,
  output logic [2:0] pwm_negative
);
  logic [1:0] startFf;
  logic [1:0] modeFf;
  logic olsPosFf, olsNegFf;
  logic [2:0] bufEnFf;
  logic [2:0] srcSel0Ff, srcSel1Ff;
  logic [2:0] statusFf;
  logic [CW-1:0] cnt0Ff, cnt1Ff, periodFf;
  logic [CW-1:0] grFf [3];
  logic [CW-1:0] bufFf [3];
  cpwm_xfer_t xfModeFf [3];
  logic [CW-1:0] capFf [2];
  logic dir0UpFf, dir1UpFf;
  logic wrPendFf;
  logic [7:0] wrAddrFf;
  logic [2:0] tickSyncFf [2];
  logic [1:0] capSyncFf [2];
  logic capEdgeFf [2];
  logic [2:0] pwmPosFf, pwmNegFf;
  cpwm_mode_t mode;
  logic [1:0] tick;
  logic periodHit, underHit, compMode, wrEn;
  logic [2:0] xfer;

  assign mode = cpwm_mode_t'(modeFf);
  assign compMode = mode == CPWM_MODE_CUDF || mode == CPWM_MODE_CMAT;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wrEn = wrPendFf;

  function automatic logic srcClk(input logic [2:0] sel, input logic b, input logic m,
                                  input logic f);
    case (sel)
      `CPWM_SRC_40M: srcClk = m; // [RULE_06]
      `CPWM_SRC_FAST: srcClk = f; // [RULE_05]
      default: srcClk = b;
    endcase
  endfunction

  // Count sources are slow inputs; rising edges become one-cycle enables
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tickSyncFf[0] <= 3'h0;
      tickSyncFf[1] <= 3'h0;
    end else begin
      tickSyncFf[0] <= {tickSyncFf[0][1:0], srcClk(srcSel0Ff, base_peripheral_clock,
                        internal_40mhz_clock, fast_internal_osc_clock)};
      tickSyncFf[1] <= {tickSyncFf[1][1:0], srcClk(srcSel1Ff, base_peripheral_clock,
                        internal_40mhz_clock, fast_internal_osc_clock)};
    end
  end
  assign tick[0] = startFf[0] && tickSyncFf[0][1] && !tickSyncFf[0][2];
  assign tick[1] = startFf[1] && tickSyncFf[1][1] && !tickSyncFf[1][2];

  assign periodHit = tick[0] && compMode && dir0UpFf && cnt0Ff == periodFf; // [RULE_15]
  assign underHit = tick[1] && compMode && !dir1UpFf && cnt1Ff == {CW{1'b0}}; // [RULE_18]

  // Buffer transfer timing per duty channel, with out-of-range overrides
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gXfer
      assign xfer[gi] = bufEnFf[gi] && (xfModeFf[gi] == CPWM_XF_HIGH ? underHit : // [RULE_20]
                        xfModeFf[gi] == CPWM_XF_ZERO ? periodHit : // [RULE_21]
                        (mode == CPWM_MODE_CMAT ? periodHit : // [RULE_16]
                        mode == CPWM_MODE_CUDF && underHit)); // [RULE_19]
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          xfModeFf[gi] <= CPWM_XF_NORMAL;
        end else if (xfer[gi]) begin
          // Leave the override only after one transfer of a valid value
          if (bufFf[gi] == {CW{1'b0}}) begin
            xfModeFf[gi] <= CPWM_XF_ZERO; // [RULE_21]
          end else if (bufFf[gi] >= periodFf) begin
            xfModeFf[gi] <= CPWM_XF_HIGH; // [RULE_20]
          end else begin
            xfModeFf[gi] <= CPWM_XF_NORMAL;
          end
        end else if (bufEnFf[gi]) begin
          if (bufFf[gi] == {CW{1'b0}}) begin
            xfModeFf[gi] <= CPWM_XF_ZERO;
          end else if (bufFf[gi] >= periodFf) begin
            xfModeFf[gi] <= CPWM_XF_HIGH;
          end
        end
      end
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          grFf[gi] <= {CW{1'b0}};
          bufFf[gi] <= {CW{1'b0}};
        end else begin
          if (xfer[gi]) begin
            grFf[gi] <= bufFf[gi]; // [RULE_16]
          end else if (wrEn && wrAddrFf == `CPWM_OFS_GR_B0 + 8'(gi * 4)) begin
            grFf[gi] <= hwdata[CW-1:0];
          end
          if (wrEn && wrAddrFf == `CPWM_OFS_BUF_D0 + 8'(gi * 4)) begin
            bufFf[gi] <= hwdata[CW-1:0];
          end
        end
      end
    end
  endgenerate

  // AHB-Lite: zero-wait writes take hwdata in the cycle after address
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrPendFf <= 1'b0;
      wrAddrFf <= 8'h00;
    end else if (hready) begin
      wrPendFf <= hsel && htrans[1] && hwrite;
      wrAddrFf <= {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        `CPWM_OFS_START: hrdata <= {30'h0, startFf};
        `CPWM_OFS_FUNC: hrdata <= {25'h0, bufEnFf, olsNegFf, olsPosFf, modeFf};
        `CPWM_OFS_CTRL0: hrdata <= {29'h0, srcSel0Ff};
        `CPWM_OFS_CTRL1: hrdata <= {29'h0, srcSel1Ff};
        `CPWM_OFS_STATUS: hrdata <= {29'h0, statusFf};
        `CPWM_OFS_CNT0: hrdata <= {16'h0, cnt0Ff};
        `CPWM_OFS_CNT1: hrdata <= {16'h0, cnt1Ff};
        `CPWM_OFS_PERIOD: hrdata <= {16'h0, periodFf};
        `CPWM_OFS_GR_B0: hrdata <= {16'h0, grFf[0]};
        `CPWM_OFS_GR_A1: hrdata <= {16'h0, grFf[1]};
        `CPWM_OFS_GR_B1: hrdata <= {16'h0, grFf[2]};
        `CPWM_OFS_BUF_D0: hrdata <= {16'h0, bufFf[0]};
        `CPWM_OFS_BUF_C1: hrdata <= {16'h0, bufFf[1]};
        `CPWM_OFS_BUF_D1: hrdata <= {16'h0, bufFf[2]};
        `CPWM_OFS_CAP0: hrdata <= {16'h0, capFf[0]};
        `CPWM_OFS_CAP1: hrdata <= {16'h0, capFf[1]};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // Control fields; source select is software's to change only while stopped
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      startFf <= 2'b00;
      modeFf <= 2'b00;
      olsPosFf <= 1'b0;
      olsNegFf <= 1'b0;
      bufEnFf <= 3'b000;
      srcSel0Ff <= 3'h0;
      srcSel1Ff <= 3'h0;
      periodFf <= `CPWM_PERIOD_RST;
    end else if (wrEn) begin
      case (wrAddrFf)
        `CPWM_OFS_START: startFf <= hwdata[1:0];
        `CPWM_OFS_FUNC: begin
          modeFf <= hwdata[1:0];
          olsPosFf <= hwdata[2];
          olsNegFf <= hwdata[3];
          bufEnFf <= hwdata[6:4];
        end
        `CPWM_OFS_CTRL0: srcSel0Ff <= hwdata[2:0]; // [RULE_01]
        `CPWM_OFS_CTRL1: srcSel1Ff <= hwdata[2:0];
        `CPWM_OFS_PERIOD: periodFf <= hwdata[CW-1:0];
        default: ;
      endcase
    end
  end

  // Flags: hardware set wins over a write-zero clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      statusFf <= 3'h0;
    end else begin
      statusFf[`CPWM_ST_PMF] <= periodHit ||
        (statusFf[`CPWM_ST_PMF] && !(wrEn && wrAddrFf == `CPWM_OFS_STATUS &&
        !hwdata[`CPWM_ST_PMF])); // [RULE_15] [RULE_17]
      statusFf[`CPWM_ST_UDF] <= underHit ||
        (statusFf[`CPWM_ST_UDF] && !(wrEn && wrAddrFf == `CPWM_OFS_STATUS &&
        !hwdata[`CPWM_ST_UDF])); // [RULE_18]
      // Overflow only outside the complementary modes (00b and 01b); untouched at the turn
      statusFf[`CPWM_ST_OVF] <= (tick[0] && !compMode && cnt0Ff == {CW{1'b1}}) ||
        (statusFf[`CPWM_ST_OVF] && !(wrEn && wrAddrFf == `CPWM_OFS_STATUS &&
        !hwdata[`CPWM_ST_OVF])); // [RULE_19]
    end
  end

  // Up/down counters; channel 1 runs below channel 0 by the offset software loads into CNT0/CNT1, forming dead time
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt0Ff <= {CW{1'b0}};
      dir0UpFf <= 1'b1;
    end else begin
      if (!compMode) begin
        dir0UpFf <= 1'b1; // Entry always passes 00b, so counting restarts upward
      end
      if (wrEn && wrAddrFf == `CPWM_OFS_CNT0) begin
        cnt0Ff <= hwdata[CW-1:0];
      end else if (tick[0] && compMode && dir0UpFf && cnt0Ff == periodFf + 1'b1) begin
        dir0UpFf <= 1'b0; // [RULE_15]
        cnt0Ff <= cnt0Ff - 1'b1;
      end else if (tick[0] && compMode && !dir0UpFf && cnt0Ff == {CW{1'b0}}) begin
        dir0UpFf <= 1'b1;
        cnt0Ff <= cnt0Ff + 1'b1;
      end else if (tick[0] && (!compMode || dir0UpFf)) begin
        cnt0Ff <= cnt0Ff + 1'b1; // [RULE_22]
      end else if (tick[0]) begin
        cnt0Ff <= cnt0Ff - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt1Ff <= {CW{1'b0}};
      dir1UpFf <= 1'b1;
    end else begin
      if (!compMode) begin
        dir1UpFf <= 1'b1;
      end
      if (wrEn && wrAddrFf == `CPWM_OFS_CNT1) begin
        cnt1Ff <= hwdata[CW-1:0];
      end else if (tick[1]) begin
        if (compMode && !dir1UpFf && cnt1Ff != {CW{1'b1}}) begin
          cnt1Ff <= cnt1Ff - 1'b1; // [RULE_18] [RULE_22]
        end else if (compMode && !dir1UpFf) begin
          dir1UpFf <= 1'b1;
          cnt1Ff <= cnt1Ff + 1'b1;
        end else begin
          cnt1Ff <= cnt1Ff + 1'b1;
          if (compMode && cnt1Ff == periodFf) begin
            dir1UpFf <= 1'b0;
          end
        end
      end
    end
  end

  // Capture: edge seen two cycles after the pin, counter stored on the third
  generate
    for (gi = 0; gi < 2; gi++) begin : gCap
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          capSyncFf[gi] <= 2'b00;
          capEdgeFf[gi] <= 1'b0;
          capFf[gi] <= {CW{1'b0}};
        end else begin
          capSyncFf[gi] <= {capSyncFf[gi][0], capture_in[gi]};
          capEdgeFf[gi] <= capSyncFf[gi][1];
          if (capSyncFf[gi][1] && !capEdgeFf[gi] && !compMode) begin
            capFf[gi] <= gi == 0 ? cnt0Ff : cnt1Ff; // [RULE_08]
          end
        end
      end
    end
  endgenerate

  // Outputs: positive leaves its initial level while cnt0 exceeds duty, negative while cnt1 does not; idle at initial levels
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pwmPosFf <= 3'h0;
      pwmNegFf <= 3'h0;
    end else if (!compMode || startFf != 2'b11) begin
      pwmPosFf <= {3{olsPosFf}};
      pwmNegFf <= {3{olsNegFf}};
    end else begin
      for (int i = 0; i < 3; i++) begin
        pwmPosFf[i] <= (cnt0Ff > grFf[i]) ^ olsPosFf;
        pwmNegFf[i] <= (cnt1Ff <= grFf[i]) ^ olsNegFf;
      end
    end
  end
  assign pwm_positive = pwmPosFf;
  assign pwm_negative = pwmNegFf;
endmodule

/* File: verif/cpwm_timer_monitor.sv */
// Port checker for the PWM timer bus slave
`timescale 1ns/1ps
module cpwm_timer_monitor (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  wire logic rdTake = hsel && htrans[1] && hready && !hwrite;
  wire logic wrTake = hsel && htrans[1] && hready && hwrite;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_hold; !rdTake |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_wrhold; wrTake ##1 !rdTake |=> $stable(hrdata); endproperty
  a_wrhold: assert property (p_wrhold) else $error("write disturbed read data");
  property p_rdzero; rdTake |=> hreadyout; endproperty
  a_rdzero: assert property (p_rdzero) else $error("read data phase stalled");
  property p_wrzero; wrTake |=> hreadyout ##1 hreadyout; endproperty
  a_wrzero: assert property (p_wrzero) else $error("write data phase stalled");
  property p_rdresp; rdTake |=> !hresp [*2]; endproperty
  a_rdresp: assert property (p_rdresp) else $error("read not okay");
  property p_idle; !hsel [*2] |=> $stable(hrdata) && hreadyout; endproperty
  a_idle: assert property (p_idle) else $error("idle bus disturbed");
endmodule
bind cpwm_timer cpwm_timer_monitor u_mon (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp));

/* File: verif/cpwm_stage_model.sv */
// External capture source beside the power stage
`timescale 1ns/1ps
module cpwm_stage_model (
  input wire logic ref_clk,
  input wire logic [1:0] fire,
  output logic [1:0] capture_in
);
  int hold = 0;
  initial capture_in = 2'h0;
  // Pulse kept four clocks, one spare over the minimum
  always @(posedge ref_clk) begin
    if (fire != 2'h0) begin
      capture_in <= fire;
      hold <= 4;
    end else if (hold > 1) hold <= hold - 1;
    else capture_in <= 2'h0;
  end
endmodule

/* File: verif/tb_complementary_pwm_timer.sv */
// Self-checking bench for the complementary PWM timer
`timescale 1ns/1ps
`include "cpwm_params.svh"
module tb_complementary_pwm_timer import cpwm_pkg::*; ;
  logic ref_clk = 0;
  logic nrst = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [1:0] fire = 2'h0;
  logic [1:0] capIn;
  logic [2:0] src = 3'h0;
  logic [2:0] pPos, pNeg;
  logic [31:0] hwdata = 32'h0, hrdata, rd, seed = 32'd73892;
  logic hreadyout, hresp;
  int error_cnt = 0, n_compared = 0, m, b, mcnt, u;
  always #25 ref_clk = ~ref_clk;
  cpwm_timer uut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .base_peripheral_clock(src[0]),
    .internal_40mhz_clock(src[1]), .fast_internal_osc_clock(src[2]), .capture_in(capIn),
    .pwm_positive(pPos), .pwm_negative(pNeg));
  cpwm_stage_model stage (.ref_clk(ref_clk), .fire(fire), .capture_in(capIn));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic edges(input int s, input int n);
    repeat (n) begin
      @(posedge ref_clk) src[s] <= 1'b1;
      @(posedge ref_clk) src[s] <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    bus(1, 8'h40, 32'hffffffff);
    bus(0, 8'h40, 0);
    chk(rd, 0);
    // Only the selected source may advance the count
    for (int s = 0; s < 3; s++) begin
      bus(1, `CPWM_OFS_START, 0);
      bus(1, `CPWM_OFS_CTRL0, s == 0 ? 0 : s == 1 ? `CPWM_SRC_40M : `CPWM_SRC_FAST);
      seed = lfsr(seed);
      mcnt = seed[15:0] | 16'hfff0;
      bus(1, `CPWM_OFS_CNT0, mcnt);
      bus(1, `CPWM_OFS_START, 1);
      edges((s + 1) % 3, 2);
      edges(s, 20);
      bus(1, `CPWM_OFS_START, 0);
      bus(0, `CPWM_OFS_CNT0, 0);
      chk(rd, (mcnt + 20) & 32'hffff);
    end
    b = seed[31:16];
    bus(1, `CPWM_OFS_CNT1, b);
    fire <= 2'h3;
    @(posedge ref_clk) fire <= 2'h0;
    repeat (8) @(posedge ref_clk);
    bus(0, `CPWM_OFS_CAP0, 0);
    chk(rd, (mcnt + 20) & 32'hffff);
    bus(0, `CPWM_OFS_CAP1, 0);
    chk(rd, b);
    bus(1, `CPWM_OFS_CTRL0, 0);
    m = 8;
    bus(1, `CPWM_OFS_PERIOD, m);
    bus(1, `CPWM_OFS_FUNC, 0);
    bus(1, `CPWM_OFS_FUNC, CPWM_MODE_RSYNC);
    bus(0, `CPWM_OFS_FUNC, 0);
    chk(rd, CPWM_MODE_RSYNC);
    // Normal match, normal underflow, zero duty, duty at or above period
    for (int k = 0; k < 4; k++) begin
      u = k % 2;
      seed = lfsr(seed);
      b = k == 2 ? 0 : k == 3 ? m + 2 : 1 + seed[2:0] % (m - 1);
      bus(1, `CPWM_OFS_FUNC, 0);
      bus(1, `CPWM_OFS_BUF_D0, b);
      bus(1, `CPWM_OFS_GR_B0, 16'h5555);
      // Underflow runs start channel 1 at the period and keep channel 0 clear of it
      bus(1, `CPWM_OFS_CNT0, u ? m + 2 : m - 1);
      bus(1, `CPWM_OFS_CNT1, u ? m : 4);
      bus(1, `CPWM_OFS_FUNC,
          {25'h0, 3'h7, 2'h3, k % 3 ? CPWM_MODE_CUDF : CPWM_MODE_CMAT});
      bus(1, `CPWM_OFS_STATUS, 0);
      bus(1, `CPWM_OFS_START, 3);
      edges(0, u ? 11 : 2);
      bus(1, `CPWM_OFS_START, 0);
      bus(0, `CPWM_OFS_STATUS, 0);
      chk(rd[2:0], u ? 3'h2 : 3'h1);
      chk({pPos, pNeg}, 32'h3f);
      bus(0, `CPWM_OFS_GR_B0, 0);
      chk(rd, b);
      bus(0, u ? `CPWM_OFS_CNT1 : `CPWM_OFS_CNT0, 0);
      chk(rd, u ? 32'hffff : m + 1);
      bus(1, `CPWM_OFS_STATUS, 0);
      bus(1, `CPWM_OFS_START, 3);
      edges(0, 2);
      bus(1, `CPWM_OFS_START, 0);
      bus(0, `CPWM_OFS_STATUS, 0);
      chk(rd[2:0], 3'h0);
      bus(0, u ? `CPWM_OFS_CNT1 : `CPWM_OFS_CNT0, 0);
      chk(rd, u ? 1 : m - 1);
      bus(1, `CPWM_OFS_FUNC, 0);
    end
    test_done();
  end
endmodule
